//--- rtl/wsfr_map.svh
/*
 * Offsets, field positions and reset values of the windowed register bank.
 * Assumes inclusion by the bank package and module only.
 */
`ifndef WSFR_MAP_SVH
`define WSFR_MAP_SVH
`define WSFR_A_ZERO_LO 5'h00
`define WSFR_A_ZERO_HI 5'h01
`define WSFR_A_CAP_MODE 5'h03
`define WSFR_A_EVT_LO 5'h04
`define WSFR_A_EVT_HI 5'h05
`define WSFR_A_CMD 5'h06
`define WSFR_A_SBUF 5'h07
`define WSFR_A_IEN_LO 5'h08
`define WSFR_A_IFL_LO 5'h09
`define WSFR_A_T1_LO 5'h0A
`define WSFR_A_T1_HI 5'h0B
`define WSFR_A_T2_LO 5'h0C
`define WSFR_A_T2_HI 5'h0D
`define WSFR_A_P0 5'h0E
`define WSFR_A_P1 5'h0F
`define WSFR_A_P2 5'h10
`define WSFR_A_SER 5'h11
`define WSFR_A_IFL_HI 5'h12
`define WSFR_A_IEN_HI 5'h13
`define WSFR_A_WIN 5'h14
`define WSFR_A_IO0 5'h15
`define WSFR_A_IO1 5'h16
`define WSFR_A_IO2 5'h17
`define WSFR_A_SP_LO 5'h18
`define WSFR_A_SP_HI 5'h19
`define WSFR_WIN_0 8'h00
`define WSFR_WIN_1 8'h01
`define WSFR_WIN_15 8'h0F
`define WSFR_RST_ZERO8 8'h00
`define WSFR_RST_ZERO16 16'h0000
`define WSFR_RST_CAP_MODE 8'hFF
`define WSFR_RST_SERIAL 8'h0B
`define WSFR_RST_BAUD 16'h0001
`define WSFR_RST_IO_CONTROL_ONE 8'h21
`define WSFR_RST_IO_CONTROL_THIRD 8'hF0
`define WSFR_RST_P1 8'hFF
`define WSFR_RST_P2 8'hC1
`define WSFR_RST_CFG 8'h2F
`define WSFR_P2_FIXED_MASK 8'hE1
`endif

//--- rtl/wsfr_pkg.sv
/*
 * Types of the windowed register bank.
 * Assumes the map header supplies all numbers.
 */
package wsfr_pkg;
	typedef struct packed {
		logic [7:0] win;
		logic [7:0] cap_mode;
		logic [15:0] evt_time;
		logic [7:0] evt_cmd;
		logic [7:0] cap_state;
		logic [7:0] serial_transmit_buffer;
		logic [7:0] ien_lo;
		logic [7:0] ifl_lo;
		logic [7:0] ien_hi;
		logic [7:0] ifl_hi;
		logic [7:0] wdog;
		logic [7:0] io_control_second;
		logic [15:0] t1;
		logic [15:0] t2;
		logic [15:0] t2cap;
		logic [15:0] baud;
		logic [15:0] t3;
		logic [7:0] watchdog_prescaler;
		logic [15:0] prio;
		logic [15:0] xfer_srv;
		logic [15:0] xfer_sel;
		logic [7:0] p1;
		logic [7:0] p2;
		logic [7:0] processor_status_word;
		logic [7:0] ser_setup;
		logic [7:0] ser_state;
		logic [7:0] io_control_first;
		logic [7:0] io_control_one;
		logic [7:0] io_control_third;
		logic [7:0] ecc;
		logic [7:0] pwm0;
		logic [7:0] pwm1;
		logic [7:0] pwm2;
		logic [15:0] sp;
		logic [7:0] rdata;
		logic irq;
	} wsfr_state_t;
endpackage : wsfr_pkg

//--- rtl/wsfr_bank.sv
/*
 * Windowed special-function register bank, byte addresses 00H to 19H.
 * Assumes a one-cycle strobe port from the core and synchronous inputs.
 */
// Operation
// - Window selector at 014H, reset 00
// - Window 0 reads and writes differ
// - Window 15 gives opposite access direction
// - Interrupt masks, flags everywhere, reset 00
// - 011H reads serial state, writes setup
// - Baud divisor written 00EH, reset 0001
// - 016H control one 21, state 00
// - Capture mode written 003H, reset FF
// - IO control three 00CH window 1
// - Port two reset 110X XXX1
// - Timers reset to 0000
// - Error correction register 015H window 1
// - Pulse width controls mapped, reset 00
// - Priority word 00AH window 1
// - Transfer service/select in window 1
// - Chip config low bits 101111
`timescale 1ns/10ps
`include "wsfr_map.svh"
module wsfr_bank
(
	input wire logic mclk_i,
	input wire logic resetn_i,
	input wire logic [4:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	input wire logic [7:0] port0_i,
	input wire logic [7:0] io_state0_i,
	input wire logic [7:0] io_state1_i,
	input wire logic [7:0] io_state2_i,
	input wire logic [15:0] cap_time_i,
	input wire logic [7:0] serial_receive_buffer_i,
	input wire logic [7:0] ser_state_i,
	input wire logic [7:0] cap_state_i,
	input wire logic [15:0] irq_event_i,
	output logic [7:0] rdata_o,
	output logic [7:0] window_o,
	output logic [15:0] baud_o,
	output logic [7:0] io_control_one_o,
	output logic [7:0] chip_config_o,
	output logic irq_o
);
	wsfr_pkg::wsfr_state_t st_ff;
	wsfr_pkg::wsfr_state_t nxt_st;
	logic [7:0] cfg_ff;
	logic w0;
	logic w1;
	logic w15;
	logic [7:0] rd_mux;
	logic [7:0] fl_lo_set;
	logic [7:0] fl_hi_set;

	// Window decode: windows other than 0, 1 and 15 see only global registers
	assign w0 = (st_ff.win == `WSFR_WIN_0);
	assign w1 = (st_ff.win == `WSFR_WIN_1);
	assign w15 = (st_ff.win == `WSFR_WIN_15);

	// Read multiplexer, combinational; sampled into rdata next cycle
	always_comb
	begin
		rd_mux = 8'h00; // Reserved and zero register read zero
		unique case (addr_i)
			`WSFR_A_CAP_MODE: if (w15) rd_mux = st_ff.cap_mode;
			`WSFR_A_EVT_LO:
			begin
				if (w0) rd_mux = cap_time_i[7:0];
				else if (w1) rd_mux = st_ff.xfer_sel[7:0];
				else if (w15) rd_mux = st_ff.evt_time[7:0];
			end
			`WSFR_A_EVT_HI:
			begin
				if (w0) rd_mux = cap_time_i[15:8];
				else if (w1) rd_mux = st_ff.xfer_sel[15:8];
				else if (w15) rd_mux = st_ff.evt_time[15:8];
			end
			`WSFR_A_CMD:
			begin
				if (w0) rd_mux = cap_state_i;
				else if (w1) rd_mux = st_ff.xfer_srv[7:0];
				else if (w15) rd_mux = st_ff.evt_cmd;
			end
			`WSFR_A_SBUF:
			begin
				if (w0) rd_mux = serial_receive_buffer_i;
				else if (w1) rd_mux = st_ff.xfer_srv[15:8];
				else if (w15) rd_mux = st_ff.serial_transmit_buffer;
			end
			`WSFR_A_IEN_LO: rd_mux = st_ff.ien_lo;
			`WSFR_A_IFL_LO: rd_mux = st_ff.ifl_lo;
			`WSFR_A_T1_LO:
			begin
				if (w0) rd_mux = st_ff.t1[7:0];
				else if (w1) rd_mux = st_ff.prio[7:0];
				else if (w15) rd_mux = st_ff.wdog;
			end
			`WSFR_A_T1_HI:
			begin
				if (w0) rd_mux = st_ff.t1[15:8];
				else if (w1) rd_mux = st_ff.prio[15:8];
				else if (w15) rd_mux = st_ff.io_control_second;
			end
			`WSFR_A_T2_LO:
			begin
				if (w0) rd_mux = st_ff.t2[7:0];
				else if (w1) rd_mux = st_ff.io_control_third;
				else if (w15) rd_mux = st_ff.t2cap[7:0];
			end
			`WSFR_A_T2_HI:
			begin
				if (w0) rd_mux = st_ff.t2[15:8];
				else if (w1) rd_mux = st_ff.watchdog_prescaler;
				else if (w15) rd_mux = st_ff.t2cap[15:8];
			end
			`WSFR_A_P0:
			begin
				if (w0) rd_mux = port0_i;
				else if (w1) rd_mux = st_ff.t3[7:0];
			end
			`WSFR_A_P1:
			begin
				if (w0) rd_mux = st_ff.p1;
				else if (w1) rd_mux = st_ff.t3[15:8];
			end
			`WSFR_A_P2:
			begin
				if (w0) rd_mux = st_ff.p2;
				else if (w15) rd_mux = st_ff.processor_status_word;
			end
			`WSFR_A_SER:
			begin
				if (w0) rd_mux = st_ff.ser_state;
				else if (w15) rd_mux = st_ff.ser_setup;
			end
			`WSFR_A_IFL_HI: rd_mux = st_ff.ifl_hi;
			`WSFR_A_IEN_HI: rd_mux = st_ff.ien_hi;
			`WSFR_A_WIN: rd_mux = st_ff.win;
			`WSFR_A_IO0:
			begin
				if (w0) rd_mux = io_state0_i;
				else if (w1) rd_mux = st_ff.ecc;
				else if (w15) rd_mux = st_ff.io_control_first;
			end
			`WSFR_A_IO1:
			begin
				if (w0) rd_mux = io_state1_i;
				else if (w1) rd_mux = st_ff.pwm1;
				else if (w15) rd_mux = st_ff.io_control_one;
			end
			`WSFR_A_IO2:
			begin
				if (w0) rd_mux = io_state2_i;
				else if (w1) rd_mux = st_ff.pwm2;
				else if (w15) rd_mux = st_ff.pwm0;
			end
			`WSFR_A_SP_LO: rd_mux = st_ff.sp[7:0];
			`WSFR_A_SP_HI: rd_mux = st_ff.sp[15:8];
			default: rd_mux = 8'h00;
		endcase
	end

	// Flag events, limited to the two flag bytes
	assign fl_lo_set = irq_event_i[7:0];
	assign fl_hi_set = irq_event_i[15:8];

	// Next-state: writes by window, flag sets win over software clears
	always_comb
	begin
		nxt_st = st_ff;
		nxt_st.ser_state = ser_state_i;
		nxt_st.cap_state = cap_state_i;
		nxt_st.rdata = rd_i ? rd_mux : 8'h00;
		if (wr_i)
		begin
			unique case (addr_i)
				`WSFR_A_WIN: nxt_st.win = wdata_i;
				`WSFR_A_IEN_LO: nxt_st.ien_lo = wdata_i;
				`WSFR_A_IFL_LO: nxt_st.ifl_lo = wdata_i;
				`WSFR_A_IEN_HI: nxt_st.ien_hi = wdata_i;
				`WSFR_A_IFL_HI: nxt_st.ifl_hi = wdata_i;
				`WSFR_A_SP_LO: nxt_st.sp[7:0] = wdata_i;
				`WSFR_A_SP_HI: nxt_st.sp[15:8] = wdata_i;
				`WSFR_A_CAP_MODE: if (w0) nxt_st.cap_mode = wdata_i;
				`WSFR_A_EVT_LO:
				begin
					if (w0) nxt_st.evt_time[7:0] = wdata_i;
					else if (w1) nxt_st.xfer_sel[7:0] = wdata_i;
				end
				`WSFR_A_EVT_HI:
				begin
					if (w0) nxt_st.evt_time[15:8] = wdata_i;
					else if (w1) nxt_st.xfer_sel[15:8] = wdata_i;
				end
				`WSFR_A_CMD:
				begin
					if (w0) nxt_st.evt_cmd = wdata_i;
					else if (w1) nxt_st.xfer_srv[7:0] = wdata_i;
					else if (w15) nxt_st.cap_state = wdata_i;
				end
				`WSFR_A_SBUF:
				begin
					if (w0) nxt_st.serial_transmit_buffer = wdata_i;
					else if (w1) nxt_st.xfer_srv[15:8] = wdata_i;
				end
				`WSFR_A_T1_LO:
				begin
					if (w0) nxt_st.wdog = wdata_i;
					else if (w1) nxt_st.prio[7:0] = wdata_i;
				end
				`WSFR_A_T1_HI:
				begin
					if (w0) nxt_st.io_control_second = wdata_i;
					else if (w1) nxt_st.prio[15:8] = wdata_i;
				end
				`WSFR_A_T2_LO:
				begin
					if (w0) nxt_st.t2[7:0] = wdata_i;
					else if (w1) nxt_st.io_control_third = wdata_i;
					else if (w15) nxt_st.t2cap[7:0] = wdata_i;
				end
				`WSFR_A_T2_HI:
				begin
					if (w0) nxt_st.t2[15:8] = wdata_i;
					else if (w1) nxt_st.watchdog_prescaler = wdata_i;
					else if (w15) nxt_st.t2cap[15:8] = wdata_i;
				end
				`WSFR_A_P0:
				begin
					// Divisor loads low byte then high byte on successive writes
					if (w0) nxt_st.baud = {wdata_i, st_ff.baud[15:8]};
					else if (w1) nxt_st.t3[7:0] = wdata_i;
				end
				`WSFR_A_P1:
				begin
					if (w0) nxt_st.p1 = wdata_i;
					else if (w1) nxt_st.t3[15:8] = wdata_i;
				end
				`WSFR_A_P2:
				begin
					if (w0) nxt_st.p2 = wdata_i;
					else if (w15) nxt_st.processor_status_word = wdata_i;
				end
				`WSFR_A_SER:
				begin
					if (w0) nxt_st.ser_setup = wdata_i;
					else if (w15) nxt_st.ser_state = wdata_i;
				end
				`WSFR_A_IO0:
				begin
					if (w0) nxt_st.io_control_first = wdata_i;
					else if (w1) nxt_st.ecc = wdata_i;
				end
				`WSFR_A_IO1:
				begin
					if (w0) nxt_st.io_control_one = wdata_i;
					else if (w1) nxt_st.pwm1 = wdata_i;
				end
				`WSFR_A_IO2:
				begin
					if (w0) nxt_st.pwm0 = wdata_i;
					else if (w1) nxt_st.pwm2 = wdata_i;
				end
				default: nxt_st.win = st_ff.win; // Zero word and reserved ignore writes
			endcase
		end
		// Hardware event sets after the write so a same-cycle clear loses
		nxt_st.ifl_lo = nxt_st.ifl_lo | fl_lo_set;
		nxt_st.ifl_hi = nxt_st.ifl_hi | fl_hi_set;
		nxt_st.irq = |({nxt_st.ifl_hi, nxt_st.ifl_lo} & {nxt_st.ien_hi, nxt_st.ien_lo});
	end

	// State register with reset values
	always_ff @(posedge mclk_i)
	begin
		if (!resetn_i)
		begin
			st_ff <= '0;
			st_ff.win <= `WSFR_WIN_0;
			st_ff.cap_mode <= `WSFR_RST_CAP_MODE;
			st_ff.ser_state <= `WSFR_RST_SERIAL;
			st_ff.ser_setup <= `WSFR_RST_SERIAL;
			st_ff.baud <= `WSFR_RST_BAUD;
			st_ff.io_control_one <= `WSFR_RST_IO_CONTROL_ONE;
			st_ff.io_control_third <= `WSFR_RST_IO_CONTROL_THIRD;
			st_ff.p1 <= `WSFR_RST_P1;
			st_ff.p2 <= `WSFR_RST_P2;
			cfg_ff <= `WSFR_RST_CFG;
		end
		else
		begin
			st_ff <= nxt_st;
			cfg_ff <= cfg_ff;
		end
	end

	assign rdata_o = st_ff.rdata;
	assign window_o = st_ff.win;
	assign baud_o = st_ff.baud;
	assign io_control_one_o = st_ff.io_control_one;
	assign chip_config_o = cfg_ff;
	assign irq_o = st_ff.irq;

	// Checks
	win_reset_a: assert property (@(posedge mclk_i) !resetn_i |=> window_o == 8'h00)
		else $error("window not cleared");
	win_write_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
		wr_i && addr_i == 5'h14 |=> window_o == $past(wdata_i))
		else $error("window write lost");
	zero_read_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
		rd_i && addr_i <= 5'h02 |=> rdata_o == 8'h00)
		else $error("zero word nonzero");
	mask_read_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
		rd_i && addr_i == 5'h13 |=> rdata_o == $past(st_ff.ien_hi))
		else $error("mask read wrong");
	flag_set_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
		|irq_event_i[7:0] |=> (st_ff.ifl_lo & $past(irq_event_i[7:0])) == $past(irq_event_i[7:0]))
		else $error("flag event lost");
	ser_rd_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
		rd_i && addr_i == 5'h11 && w0 |=> rdata_o == $past(st_ff.ser_state))
		else $error("serial state read wrong");
	p0_rd_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
		rd_i && addr_i == 5'h0E && w0 |=> rdata_o == $past(port0_i))
		else $error("port zero read wrong");
	io_control_one_rst_a: assert property (@(posedge mclk_i) !resetn_i |=> io_control_one_o == 8'h21 && baud_o == 16'h0001)
		else $error("control reset wrong");
	cfg_rst_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
		chip_config_o[5:0] == 6'h2F)
		else $error("config bits wrong");
	p2_rst_a: assert property (@(posedge mclk_i) !resetn_i |=> (st_ff.p2 & 8'hE1) == 8'hC1)
		else $error("port two reset wrong");
endmodule : wsfr_bank

//--- tb/test_windowed_sfr_bank.sv
/*
 * Self-checking bench for the windowed register bank: reset values, the
 * three windows, the zero word, the divisor pair and the interrupt path.
 * Assumes the one-cycle strobe port and read data one cycle after rd_i.
 */
`timescale 1ns/10ps
module test_windowed_sfr_bank;
	logic mclk_i;
	logic resetn_i;
	logic [4:0] addr_i;
	logic [7:0] wdata_i;
	logic wr_i;
	logic rd_i;
	logic [15:0] irq_event_i;
	logic [7:0] port0_i;
	logic [7:0] ser_state_i;
	logic [7:0] cap_state_i;
	logic [7:0] rdata_o;
	logic [7:0] window_o;
	logic [15:0] baud_o;
	logic [7:0] io_control_one_o;
	logic [7:0] chip_config_o;
	logic irq_o;
	int failures;
	int comparisons;

	// Distinct levels on every status input so a wrong mux leg shows up
	wsfr_bank wsfr_bank_inst (.mclk_i(mclk_i), .resetn_i(resetn_i), .addr_i(addr_i),
		.wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .port0_i(port0_i), .io_state0_i(8'h81),
		.io_state1_i(8'h96), .io_state2_i(8'h42), .cap_time_i(16'h7E18),
		.serial_receive_buffer_i(8'hD3), .ser_state_i(ser_state_i), .cap_state_i(cap_state_i),
		.irq_event_i(irq_event_i), .rdata_o(rdata_o), .window_o(window_o), .baud_o(baud_o),
		.io_control_one_o(io_control_one_o), .chip_config_o(chip_config_o), .irq_o(irq_o));

	// Free-running core clock
	initial
	begin
		mclk_i = 1'b0;
		forever #5 mclk_i = ~mclk_i;
	end

	task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
		comparisons++;
		if (g !== e)
		begin
			$display("Error %s expected %h seen %h", n, e, g);
			failures++;
		end
	endtask : chk

	// A gap cycle follows each strobe, so no strobe is assigned twice in a step
	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		@(posedge mclk_i);
		wr_i <= 1'b1;
		addr_i <= a;
		wdata_i <= d;
		@(posedge mclk_i);
		wr_i <= 1'b0;
	endtask : wr

	// Data is looked at only in the one cycle where it stands
	task automatic rd(input logic [4:0] a, input logic [7:0] e, input logic [7:0] m = 8'hFF);
		@(posedge mclk_i);
		rd_i <= 1'b1;
		addr_i <= a;
		@(posedge mclk_i);
		rd_i <= 1'b0;
		#1;
		chk($sformatf("rdata_o at %h", a), {8'h00, e}, {8'h00, rdata_o & m});
	endtask : rd

	task automatic set_win(input logic [7:0] w);
		wr(5'h14, w);
		#1;
		chk("window_o", {8'h00, w}, {8'h00, window_o});
	endtask : set_win

	task automatic t_reset();
		chk("window_o", 16'h0000, {8'h00, window_o});
		chk("baud_o", 16'h0001, baud_o);
		chk("io_control_one_o", 16'h0021, {8'h00, io_control_one_o});
		chk("chip_config_o", 16'h002F, {10'h000, chip_config_o[5:0]});
		chk("irq_o", 16'h0000, {15'h0000, irq_o});
		rd(5'h14, 8'h00);
		rd(5'h08, 8'h00);
		rd(5'h09, 8'h00);
		rd(5'h12, 8'h00);
		rd(5'h13, 8'h00);
		for (int a = 10; a < 14; a++)
			rd(a[4:0], 8'h00);
		rd(5'h10, 8'hC1, 8'hE1);
	endtask : t_reset

	task automatic t_win0();
		rd(5'h06, 8'hA5);
		wr(5'h06, 8'h5A);
		@(posedge mclk_i);
		cap_state_i <= 8'h4B;
		rd(5'h06, 8'h4B);
		rd(5'h0E, 8'h3C);
		@(posedge mclk_i);
		port0_i <= 8'hC3;
		rd(5'h0E, 8'hC3);
		wr(5'h0E, 8'h34);
		wr(5'h0E, 8'h12);
		#1;
		chk("baud_o", 16'h1234, baud_o);
		rd(5'h16, 8'h96);
		wr(5'h16, 8'h55);
		#1;
		chk("io_control_one_o", 16'h0055, {8'h00, io_control_one_o});
		wr(5'h11, 8'h3C);
		rd(5'h11, 8'h6E);
		@(posedge mclk_i);
		ser_state_i <= 8'h91;
		rd(5'h11, 8'h91);
		wr(5'h00, 8'hFF);
		wr(5'h01, 8'hFF);
		rd(5'h00, 8'h00);
		rd(5'h01, 8'h00);
	endtask : t_win0

	task automatic t_win1();
		set_win(8'h01);
		rd(5'h0C, 8'hF0);
		for (int a = 4; a < 8; a++)
			rd(a[4:0], 8'h00);
		rd(5'h0A, 8'h00);
		rd(5'h0B, 8'h00);
		rd(5'h0E, 8'h00);
		rd(5'h0F, 8'h00);
		rd(5'h15, 8'h00);
		rd(5'h16, 8'h00);
		rd(5'h17, 8'h00);
		wr(5'h0C, 8'h12);
		rd(5'h0C, 8'h12);
		rd(5'h00, 8'h00);
	endtask : t_win1

	task automatic t_win15();
		set_win(8'h0F);
		rd(5'h11, 8'h3C);
		rd(5'h06, 8'h5A);
		rd(5'h03, 8'hFF);
		rd(5'h14, 8'h0F);
	endtask : t_win15

	// Flag sets, stays sticky, drives irq_o only when enabled, write clears
	task automatic t_irq();
		@(posedge mclk_i);
		irq_event_i <= 16'h0208;
		@(posedge mclk_i);
		irq_event_i <= 16'h0000;
		rd(5'h09, 8'h08);
		rd(5'h12, 8'h02);
		chk("irq_o", 16'h0000, {15'h0000, irq_o});
		wr(5'h13, 8'h02);
		#1;
		chk("irq_o", 16'h0001, {15'h0000, irq_o});
		wr(5'h12, 8'h00);
		#1;
		chk("irq_o", 16'h0000, {15'h0000, irq_o});
		rd(5'h13, 8'h02);
	endtask : t_irq

	// Mid-run reset: registers written earlier must fall back to reset values
	task automatic t_rst2();
		@(posedge mclk_i);
		resetn_i <= 1'b0;
		repeat (2) @(posedge mclk_i);
		resetn_i <= 1'b1;
		#1;
		chk("window_o", 16'h0000, {8'h00, window_o});
		chk("baud_o", 16'h0001, baud_o);
		chk("io_control_one_o", 16'h0021, {8'h00, io_control_one_o});
		rd(5'h09, 8'h00);
		set_win(8'h0F);
		rd(5'h11, 8'h0B);
		rd(5'h06, 8'h00);
		set_win(8'h00);
	endtask : t_rst2

	task automatic end_sim();
		$display("failures %0d comparisons %0d", failures, comparisons);
		if (failures == 0 && comparisons > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : end_sim

	// Watchdog: the whole sequence needs well under a thousand cycles
	initial
	begin
		#100000;
		failures++;
		end_sim();
	end

	// Main sequence
	initial
	begin
		failures = 0;
		comparisons = 0;
		resetn_i = 1'b0;
		addr_i = 5'h00;
		wdata_i = 8'h00;
		wr_i = 1'b0;
		rd_i = 1'b0;
		irq_event_i = 16'h0000;
		port0_i = 8'h3C;
		ser_state_i = 8'h6E;
		cap_state_i = 8'hA5;
		repeat (16) @(posedge mclk_i);
		resetn_i <= 1'b1;
		#1;
		t_reset();
		t_win0();
		t_win1();
		t_win15();
		set_win(8'h00);
		t_irq();
		t_rst2();
		end_sim();
	end
endmodule : test_windowed_sfr_bank
